// file: adc_ctrl_map.vh
// register map, field positions and timing counts of the converter control unit
`ifndef ADC_CTRL_MAP_VH
`define ADC_CTRL_MAP_VH

// printed offsets are register indexes; byte address is four times
`define CTRL_IDX       8'h36
`define RHI_IDX        8'h37
`define RLO_IDX        8'h38
`define CTRL_ADDR      10'h0d8
`define RHI_ADDR       10'h0dc
`define RLO_ADDR       10'h0e0
`define ISTAT_ADDR     10'h0e4
`define IMASK_ADDR     10'h0e8

`define DONE_BIT       7
`define RATE_BIT       6
`define ON_BIT         5
`define SLOW_BIT       3
`define CH_MSB         2

`define CTRL_RST       8'h00
`define RLO_RST        8'h00
`define ISTAT_DONE     0
`define ISTAT_OVR      1

`define RES_BITS       10
`define SAMPLE_TICKS   3'h4
`define BIT_TICKS      3'h4
`define FADC_MAX_MHZ   4
`define CORE_MHZ       100
`define STAB_CYCLES    16'h0100

`endif

// file: sar_engine.v
// successive approximation sequencer: sampling and ten bit decisions
`timescale 1ns/10ps
`include "adc_ctrl_map.vh"
module sar_engine #(
  parameter W = `RES_BITS
) (
  input  wire         core_clk,
  input  wire         rst_b,
  input  wire         tick,
  input  wire         run,
  input  wire         restart,
  input  wire         cmp_hi,
  output wire         sample,
  output wire [W-1:0] trial,
  output wire         done,
  output wire [W-1:0] result
);
  localparam [1:0] S_IDLE = 2'b00;
  localparam [1:0] S_SAMP = 2'b01;
  localparam [1:0] S_BITS = 2'b10;

  reg [1:0]   state_ff;
  reg [2:0]   tcnt_ff;
  reg [3:0]   bidx_ff;
  reg [W-1:0] trial_ff;
  reg [W-1:0] result_ff;
  reg         done_ff;
  reg [1:0]   nxt_state;
  reg [2:0]   nxt_tcnt;
  reg [3:0]   nxt_bidx;
  reg [W-1:0] nxt_trial;
  reg [W-1:0] nxt_result;
  reg         nxt_done;
  reg [W-1:0] kept;

  assign sample = (state_ff == S_SAMP);
  assign trial  = trial_ff;
  assign done   = done_ff;
  assign result = result_ff;

  always @* begin
    nxt_state  = state_ff;
    nxt_tcnt   = tcnt_ff;
    nxt_bidx   = bidx_ff;
    nxt_trial  = trial_ff;
    nxt_result = result_ff;
    nxt_done   = 1'b0;
    // comparator high keeps the trial bit; all-high gives full scale, all-low zero
    kept = cmp_hi ? trial_ff : (trial_ff & ~({{(W-1){1'b0}}, 1'b1} << bidx_ff));
    if (!run) begin
      nxt_state = S_IDLE;
      nxt_tcnt  = 3'h0;
    end else if (restart) begin
      nxt_state = S_SAMP;
      nxt_tcnt  = 3'h0;
    end else begin
      case (state_ff)
        S_IDLE: begin
          nxt_state = S_SAMP;
          nxt_tcnt  = 3'h0;
        end
        S_SAMP: begin
          if (tick) begin
            nxt_tcnt = tcnt_ff + 3'h1;
            if (tcnt_ff == `SAMPLE_TICKS - 3'h1) begin
              nxt_state = S_BITS;
              nxt_tcnt  = 3'h0;
              nxt_bidx  = W[3:0] - 4'h1;
              nxt_trial = {1'b1, {(W-1){1'b0}}};
            end
          end
        end
        S_BITS: begin
          if (tick) begin
            nxt_tcnt = tcnt_ff + 3'h1;
            // comparator passes a two-stage synchroniser, so decide on the last tick
            if (tcnt_ff == `BIT_TICKS - 3'h1) begin
              nxt_tcnt = 3'h0;
              if (bidx_ff == 4'h0) begin
                nxt_result = kept;
                nxt_done   = 1'b1;
                nxt_trial  = {W{1'b0}};
                nxt_state  = S_SAMP;
              end else begin
                nxt_bidx  = bidx_ff - 4'h1;
                nxt_trial = kept | ({{(W-1){1'b0}}, 1'b1} << (bidx_ff - 4'h1));
              end
            end
          end
        end
        default: begin
          nxt_state = S_IDLE;
        end
      endcase
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff  <= S_IDLE;
      tcnt_ff   <= 3'h0;
      bidx_ff   <= 4'h0;
      trial_ff  <= {W{1'b0}};
      result_ff <= {W{1'b0}};
      done_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      tcnt_ff   <= nxt_tcnt;
      bidx_ff   <= nxt_bidx;
      trial_ff  <= nxt_trial;
      result_ff <= nxt_result;
      done_ff   <= nxt_done;
    end
  end
endmodule

// file: sar_adc_control_unit.v
// converter control unit: ahb-lite registers, clock divider, halt handling, interrupt
`timescale 1ns/10ps
`include "adc_ctrl_map.vh"
module sar_adc_control_unit #(
  parameter [15:0] STAB_CYC = `STAB_CYCLES
) (
  input  wire        core_clk,
  input  wire        rst_b,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata,
  input  wire        halt_req,
  input  wire        cmp_in,
  output wire        ana_power_on,
  output wire [2:0]  ana_chan,
  output wire        ana_sample,
  output wire [9:0]  ana_trial,
  output wire        irq
);
  // reset images of the two registers that have defined reset values
  localparam [7:0] CTRL_RV = `CTRL_RST;
  localparam [7:0] RLO_RV  = `RLO_RST;

  // bus phase state
  reg        wr_ph_ff;
  reg [9:0]  wr_addr_ff;
  reg        rd_ph_ff;
  reg        rd_rdy_ff;
  reg [9:0]  rd_addr_ff;
  reg [31:0] hrdata_ff;
  // programmer state
  reg [2:0]  chan_ff;
  reg        on_ff;
  reg        rate_ff;
  reg        slow_ff;
  reg        done_ff;
  reg [7:0]  rhi_ff;
  reg [1:0]  rlo_ff;
  reg [1:0]  ist_ff;
  reg [1:0]  imask_ff;
  // converter timing and interrupt
  reg [1:0]  div_ff;
  reg [15:0] stab_ff;
  reg        cmp_s1_ff;
  reg        cmp_s2_ff;
  reg        irq_ff;

  reg [31:0] nxt_hrdata;
  reg        nxt_done;
  reg [1:0]  nxt_ist;
  reg        tick;

  wire       addr_ok;
  wire       rd_take;
  wire       wr_take;
  wire       wr_ctrl;
  wire       wr_rlo;
  wire       wr_ist;
  wire       wr_imask;
  wire       rd_cap;
  wire       chan_chg;
  wire       run;
  wire       eng_done;
  wire [9:0] eng_res;
  wire       done_set;
  wire       done_clr;

  // zero-wait writes; reads hold one wait state so a write just before is seen
  assign hreadyout = ~(rd_ph_ff & ~rd_rdy_ff);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;

  assign addr_ok = hsel & htrans[1] & hready;
  assign rd_take = addr_ok & ~hwrite;
  assign wr_take = addr_ok & hwrite;

  assign wr_ctrl  = wr_ph_ff & (wr_addr_ff == `CTRL_ADDR);
  assign wr_rlo   = wr_ph_ff & (wr_addr_ff == `RLO_ADDR);
  assign wr_ist   = wr_ph_ff & (wr_addr_ff == `ISTAT_ADDR);
  assign wr_imask = wr_ph_ff & (wr_addr_ff == `IMASK_ADDR);
  assign rd_cap   = rd_ph_ff & ~rd_rdy_ff;

  assign chan_chg = wr_ctrl & (hwdata[`CH_MSB:0] != chan_ff);
  // halt forces the converter off and then waits out the stabilisation count
  assign run      = on_ff & ~halt_req & (stab_ff == 16'h0000);

  // a result arriving with the channel change is from the old channel
  assign done_set = eng_done & ~chan_chg;
  assign done_clr = wr_ctrl | (rd_cap & (rd_addr_ff == `RHI_ADDR));

  always @* begin
    // set wins over clear so no completion is lost
    nxt_done = done_set | (done_ff & ~done_clr);
    nxt_ist  = ist_ff;
    if (wr_ist) begin
      nxt_ist = ist_ff & ~hwdata[1:0];
    end
    if (done_set) begin
      nxt_ist[`ISTAT_DONE] = 1'b1;
    end
    if (done_set & done_ff & ~done_clr) begin
      nxt_ist[`ISTAT_OVR] = 1'b1;
    end
  end

  // conversion clock as a tick: full rate, half or quarter of core_clk
  always @* begin
    if (slow_ff) begin
      tick = (div_ff == 2'b11);
    end else if (rate_ff) begin
      tick = 1'b1;
    end else begin
      tick = div_ff[0];
    end
  end

  always @* begin
    nxt_hrdata = 32'h0000_0000;
    case (rd_addr_ff)
      `CTRL_ADDR: begin
        nxt_hrdata[7:0] = {done_ff, rate_ff, on_ff, 2'b00, chan_ff};
      end
      `RHI_ADDR: begin
        nxt_hrdata[7:0] = rhi_ff;
      end
      `RLO_ADDR: begin
        nxt_hrdata[7:0] = {4'h0, slow_ff, 1'b0, rlo_ff};
      end
      `ISTAT_ADDR: begin
        nxt_hrdata[1:0] = ist_ff;
      end
      `IMASK_ADDR: begin
        nxt_hrdata[1:0] = imask_ff;
      end
      default: begin
        nxt_hrdata = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ph_ff   <= 1'b0;
      wr_addr_ff <= 10'h000;
      rd_ph_ff   <= 1'b0;
      rd_rdy_ff  <= 1'b0;
      rd_addr_ff <= 10'h000;
      hrdata_ff  <= 32'h0000_0000;
    end else begin
      wr_ph_ff <= wr_take;
      if (wr_take) begin
        wr_addr_ff <= haddr[9:0];
      end
      if (rd_take) begin
        rd_ph_ff   <= 1'b1;
        rd_rdy_ff  <= 1'b0;
        rd_addr_ff <= haddr[9:0];
      end else if (rd_cap) begin
        rd_rdy_ff <= 1'b1;
        hrdata_ff <= nxt_hrdata;
      end else if (rd_rdy_ff) begin
        rd_ph_ff  <= 1'b0;
        rd_rdy_ff <= 1'b0;
      end
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      chan_ff  <= CTRL_RV[`CH_MSB:0];
      on_ff    <= CTRL_RV[`ON_BIT];
      rate_ff  <= CTRL_RV[`RATE_BIT];
      slow_ff  <= RLO_RV[`SLOW_BIT];
      done_ff  <= CTRL_RV[`DONE_BIT];
      ist_ff   <= 2'b00;
      imask_ff <= 2'b00;
    end else begin
      if (wr_ctrl) begin
        // bits 4:3 are not stored; they read back zero
        chan_ff <= hwdata[`CH_MSB:0];
        on_ff   <= hwdata[`ON_BIT];
        rate_ff <= hwdata[`RATE_BIT];
      end
      if (wr_rlo) begin
        slow_ff <= hwdata[`SLOW_BIT];
      end
      if (wr_imask) begin
        imask_ff <= hwdata[1:0];
      end
      done_ff <= nxt_done;
      ist_ff  <= nxt_ist;
    end
  end

  // result split: high register keeps 9:2, low register keeps 1:0
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rhi_ff <= 8'h00;
      rlo_ff <= 2'b00;
    end else if (done_set) begin
      rhi_ff <= eng_res[9:2];
      rlo_ff <= eng_res[1:0];
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_ff    <= 2'b00;
      stab_ff   <= 16'h0000;
      cmp_s1_ff <= 1'b0;
      cmp_s2_ff <= 1'b0;
      irq_ff    <= 1'b0;
    end else begin
      div_ff    <= div_ff + 2'b01;
      cmp_s1_ff <= cmp_in;
      cmp_s2_ff <= cmp_s1_ff;
      irq_ff    <= |(nxt_ist & imask_ff);
      if (halt_req) begin
        stab_ff <= STAB_CYC;
      end else if (stab_ff != 16'h0000) begin
        stab_ff <= stab_ff - 16'h0001;
      end
    end
  end

  assign ana_power_on = run;
  assign ana_chan     = chan_ff;
  assign irq          = irq_ff;

  sar_engine #(
    .W (`RES_BITS)
  ) u_sar (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .tick     (tick),
    .run      (run),
    .restart  (chan_chg),
    .cmp_hi   (cmp_s2_ff),
    .sample   (ana_sample),
    .trial    (ana_trial),
    .done     (eng_done),
    .result   (eng_res)
  );
endmodule

// file: sar_adc_checker_assertions.sv
// port-level checks of the converter control unit
`timescale 1ns/10ps
module sar_adc_checker #(
  parameter [15:0] STAB_CYC = 16'h0100
) (
  input wire        core_clk,
  input wire        rst_b,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire [31:0] hrdata,
  input wire        halt_req,
  input wire        ana_power_on,
  input wire [2:0]  ana_chan,
  input wire        ana_sample
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_rd(a);
    hsel && htrans[1] && hready && !hwrite && haddr[9:0] == a;
  endsequence
  // ends in the data phase, where hwdata stands
  sequence s_wr_ctrl;
    hsel && htrans[1] && hready && hwrite && haddr[9:0] == 10'h0d8 ##1 1'b1;
  endsequence
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write stalled");
  a_low_reserved: assert property (s_rd(10'h0e0) |-> ##2 hrdata[7:4] == 4'h0 && !hrdata[2] && hrdata[31:8] == 0)
    else $error("low result reserved bits set");
  a_ctrl_reserved: assert property (s_rd(10'h0d8) |-> ##2 hrdata[4:3] == 2'h0 && hrdata[31:8] == 0)
    else $error("control reserved bits set");
  a_chan_follow: assert property (s_wr_ctrl |=> ana_chan == $past(hwdata[2:0]))
    else $error("channel not applied");
  a_off_unpowered: assert property (s_wr_ctrl ##0 !hwdata[5] |=> !ana_power_on)
    else $error("converter still powered");
  a_halt_unpowered: assert property (halt_req |-> !ana_power_on)
    else $error("powered in halt");
  a_sample_bound: assert property ($rose(ana_sample) |-> ##[1:16] !ana_sample)
    else $error("sampling too long");
endmodule
bind sar_adc_control_unit sar_adc_checker #(.STAB_CYC(STAB_CYC)) i_chk (
  .core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .halt_req(halt_req), .ana_power_on(ana_power_on), .ana_chan(ana_chan), .ana_sample(ana_sample));

// file: adc_analog_model.sv
// behavioural mux and comparator
`timescale 1ns/10ps
module adc_analog_model (
  input  wire        core_clk,
  input  wire        ana_power_on,
  input  wire [2:0]  ana_chan,
  input  wire [9:0]  ana_trial,
  input  wire [54:0] levels,
  output logic       cmp_in
);
  logic        tog = 1'b0;
  logic [10:0] lvl;
  // unpowered comparator output is junk, so it toggles
  always @(posedge core_clk) begin
    tog <= ~tog;
  end
  assign lvl    = (ana_chan < 3'h5) ? levels[ana_chan * 11 +: 11] : 11'h000;
  assign cmp_in = ana_power_on ? (lvl > {ana_trial, 1'b0}) : tog;
endmodule

// file: sar_adc_control_unit_test.sv
// bench for the converter control unit
`timescale 1ns/10ps
`include "adc_ctrl_map.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; $display("Error %0t: %h not %h", $time, g, e); end end
module sar_adc_control_unit_test;
  logic        core_clk  = 1'b0;
  logic        rst_b     = 1'b0;
  logic        hsel      = 1'b0;
  logic [31:0] haddr     = 32'h0;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'b0;
  logic [31:0] hwdata    = 32'h0;
  logic        halt_req  = 1'b0;
  logic [7:0]  rd;
  int          err_total = 0;
  int          tests_run = 0;
  wire         hreadyout, hresp, cmp_in, ana_power_on, ana_sample, irq;
  wire  [31:0] hrdata;
  wire  [2:0]  ana_chan;
  wire  [9:0]  ana_trial;
  // 11-bit levels: code*2+1 sits between codes; ch2 above, ch3 below range
  wire  [54:0] levels    = {11'h1e1, 11'h000, 11'h7ff, 11'h279, 11'h54b};

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  sar_adc_control_unit #(.STAB_CYC(16'h0004)) i_dut (
    .core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .halt_req(halt_req), .cmp_in(cmp_in), .ana_power_on(ana_power_on), .ana_chan(ana_chan),
    .ana_sample(ana_sample), .ana_trial(ana_trial), .irq(irq));
  adc_analog_model i_ana (
    .core_clk(core_clk), .ana_power_on(ana_power_on), .ana_chan(ana_chan), .ana_trial(ana_trial),
    .levels(levels), .cmp_in(cmp_in));

  task automatic end_of_test();
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic hang();
    err_total++;
    $display("Error %0t: no answer", $time);
    end_of_test();
  endtask
  task automatic step(inout int c);
    @(posedge core_clk);
    #1;
    c++;
  endtask
  // one bus phase: hold until hready is seen high at an edge
  task automatic phase(output logic [7:0] q);
    logic r;
    int   n;
    n = 0;
    do begin
      #1 r = hreadyout;
      q = hrdata[7:0];
      @(posedge core_clk);
      n++;
    end while (r !== 1'b1 && n < 20);
    if (r !== 1'b1) hang();
  endtask
  task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] wd, output logic [7:0] q);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {22'h0, a};
    phase(q);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    phase(q);
  endtask
  task automatic chk_rd(input logic [9:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h0, rd);
    `CHK(rd, e)
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      bus(1'b0, `CTRL_ADDR, 8'h0, rd);
      n++;
    end while (rd[`DONE_BIT] !== 1'b1 && n < 200);
    if (n >= 200) hang();
  endtask

  task automatic t_reset();
    chk_rd(`CTRL_ADDR, 8'h00);
    chk_rd(`RLO_ADDR, 8'h00);
    chk_rd(10'h0f0, 8'h00);
  endtask
  task automatic t_chan();
    logic [9:0] v;
    for (int ch = 0; ch < 5; ch++) begin
      v = levels[ch * 11 + 1 +: 10];
      bus(1'b1, `CTRL_ADDR, 8'h60 | ch[7:0], rd);
      wait_done();
      chk_rd(`RLO_ADDR, {6'h0, v[1:0]});
      chk_rd(`CTRL_ADDR, 8'he0 | ch[7:0]);
      chk_rd(`RHI_ADDR, v[9:2]);
      chk_rd(`CTRL_ADDR, 8'h60 | ch[7:0]);
    end
  endtask
  task automatic t_rate();
    int n;
    int w;
    bus(1'b1, `RLO_ADDR, 8'hff, rd);
    chk_rd(`RLO_ADDR, 8'h08);
    for (int k = 0; k < 4; k++) begin
      // model has no settling limit, so fast rates stand in for the slow ones
      bus(1'b1, `RLO_ADDR, {4'h0, k[1], 3'h0}, rd);
      bus(1'b1, `CTRL_ADDR, {1'b0, k[0], 6'h24}, rd);
      n = 0;
      w = 0;
      #1;
      // skip the sampling phase cut by the rate change
      repeat (2) begin
        while (ana_sample !== 1'b0 && n < 900) step(n);
        while (ana_sample !== 1'b1 && n < 900) step(n);
      end
      while (ana_sample === 1'b1 && w < 40) step(w);
      if (n >= 900) hang();
      `CHK(w, k[1] ? 16 : (k[0] ? 4 : 8))
      @(posedge core_clk);
    end
  endtask
  task automatic t_abort();
    bus(1'b1, `RLO_ADDR, 8'h00, rd);
    bus(1'b1, `CTRL_ADDR, 8'h60, rd);
    wait_done();
    bus(1'b1, `CTRL_ADDR, 8'h61, rd);
    chk_rd(`CTRL_ADDR, 8'h61);
    repeat (20) @(posedge core_clk);
    bus(1'b1, `CTRL_ADDR, 8'h64, rd);
    wait_done();
    chk_rd(`RHI_ADDR, levels[47 +: 8]);
  endtask
  task automatic t_power();
    bus(1'b1, `CTRL_ADDR, 8'h04, rd);
    repeat (100) @(negedge core_clk);
    `CHK(ana_power_on, 1'b0)
    @(posedge core_clk);
    chk_rd(`CTRL_ADDR, 8'h04);
    bus(1'b1, `CTRL_ADDR, 8'h64, rd);
    halt_req <= 1'b1;
    repeat (100) @(negedge core_clk);
    `CHK(ana_power_on, 1'b0)
    @(posedge core_clk);
    chk_rd(`CTRL_ADDR, 8'h64);
    halt_req <= 1'b0;
    @(negedge core_clk);
    `CHK(ana_power_on, 1'b0)
    @(posedge core_clk);
    wait_done();
  endtask
  task automatic t_irq();
    int n;
    n = 0;
    bus(1'b1, `ISTAT_ADDR, 8'h03, rd);
    bus(1'b1, `IMASK_ADDR, 8'h01, rd);
    #1;
    while (irq !== 1'b1 && n < 200) step(n);
    `CHK(irq, 1'b1)
    @(posedge core_clk);
    bus(1'b1, `IMASK_ADDR, 8'h00, rd);
    repeat (2) @(negedge core_clk);
    `CHK(irq, 1'b0)
    @(posedge core_clk);
    bus(1'b1, `CTRL_ADDR, 8'h00, rd);
    bus(1'b1, `ISTAT_ADDR, 8'h03, rd);
    chk_rd(`ISTAT_ADDR, 8'h00);
    bus(1'b1, `IMASK_ADDR, 8'h01, rd);
    repeat (2) @(negedge core_clk);
    `CHK(irq, 1'b0)
    @(posedge core_clk);
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_chan();
    t_rate();
    t_abort();
    t_power();
    t_irq();
    end_of_test();
  end
endmodule
